// ==== logic/ddr_pin_device.sv ====
// Device-side command decode, bank state, mode registers and data pins
`timescale 1ns/1ps
`default_nettype none
// Function
// - Decode command from chip select, row, column and write-enable strobes.
// - Ignore every command while chip select is high at the edge.
// - Sample address and control on the rising link clock edge.
// - Drop each write byte whose byte mask is high with it.
// - Sample write masks on both edges with each beat.
// - On x8 parts an extended mode bit turns the mask into read strobe.
// - Extra read strobe mirrors main strobe; masking then disabled.
// - Bank select names the bank for activate, read, write, precharge.
// - Bank select picks base or extended mode register on a mode load.
// - Address carries row on activate, column and auto-close on read/write.
// - Precharge closes named bank, or all banks with bit 10 high.
// - Mode load stores the address opcode into the selected register.
// - Data lines are shared; device drives only for reads.
// - Read strobe edges align with data; write strobe is centred.
// - Low strobe times data 0 to 7, high strobe data 8 to 15.
// - Extended bit 10 low enables all complementary strobes.
// - Read strobe pair used only when extended bit 11 enables it.
module ddr_pin_device
    import ddr_pin_pkg::*;
#(
    parameter bit X8_PART   = 1'b0,
    parameter int ROW_IDX_W = 2,
    parameter int COL_IDX_W = 3
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          diff_clock,
    input  wire logic                          chip_select_n,
    input  wire logic                          row_strobe_n,
    input  wire logic                          col_strobe_n,
    input  wire logic                          write_enable_n,
    input  wire logic                          bank_select_bit0,
    input  wire logic                          bank_select_bit1,
    input  wire logic [ddr_pin_pkg::ADDR_W-1:0] address,
    input  wire logic [ddr_pin_pkg::DQ_W-1:0]   dq_in,
    output logic      [ddr_pin_pkg::DQ_W-1:0]   dq_out,
    output logic                               dq_oe,
    input  wire logic                          low_byte_mask,
    input  wire logic                          high_byte_mask,
    input  wire logic                          low_byte_strobe_in,
    output logic                               low_byte_strobe_out,
    output logic                               low_byte_strobe_oe,
    output logic                               low_byte_strobe_n_out,
    output logic                               low_byte_strobe_n_oe,
    input  wire logic                          high_byte_strobe_in,
    output logic                               high_byte_strobe_out,
    output logic                               high_byte_strobe_oe,
    output logic                               high_byte_strobe_n_out,
    output logic                               high_byte_strobe_n_oe,
    output logic                               read_only_strobe_out,
    output logic                               read_only_strobe_oe,
    output logic                               read_only_strobe_n_out,
    output logic                               read_only_strobe_n_oe,
    output logic      [ddr_pin_pkg::ADDR_W-1:0] base_mode,
    output logic      [ddr_pin_pkg::ADDR_W-1:0] ext_mode1,
    output logic      [ddr_pin_pkg::ADDR_W-1:0] ext_mode2,
    output logic      [ddr_pin_pkg::ADDR_W-1:0] ext_mode3,
    output logic      [ddr_pin_pkg::NUM_BANKS-1:0] bank_open
);
    import ddr_pin_pkg::*;

    localparam int MEM_AW = BANK_W + ROW_IDX_W + COL_IDX_W;
    localparam logic [MEM_AW-1:0] IDX_STEP = MEM_AW'(2);
    localparam logic [1:0] PAIRS_LAST = 2'(BURST_PAIRS - 1);
    localparam logic [1:0] PAIRS_ALL  = 2'(BURST_PAIRS);
    localparam logic [1:0] LAT_LOAD   = 2'(READ_LAT);

    // Reset crossing into the link domain
    logic link_rst_s1_q;
    logic link_rst_q;

    always_ff @(posedge diff_clock)
    begin
        link_rst_s1_q <= rst;
        link_rst_q    <= link_rst_s1_q;
    end

    // Command decode straight from the pins at the rising link edge
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic              precharge_all_flag;

    assign cmd  = chip_select_n ? CMD_DESELECT
                : cmd_t'({1'b0, row_strobe_n, col_strobe_n, write_enable_n});
    assign bank = {bank_select_bit1, bank_select_bit0};
    assign precharge_all_flag = address[PRECHARGE_ALL_BIT];

    // Mode registers
    logic [ADDR_W-1:0] base_mode_q;
    logic [ADDR_W-1:0] ext1_q;
    logic [ADDR_W-1:0] ext2_q;
    logic [ADDR_W-1:0] ext3_q;

    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
        begin
            base_mode_q <= MODE_RST;
            ext1_q      <= MODE_RST;
            ext2_q      <= MODE_RST;
            ext3_q      <= MODE_RST;
        end
        else if (cmd == CMD_MODE_LOAD)
        begin
            case (bank)
                SEL_BASE: base_mode_q <= address;
                SEL_EXT1: ext1_q      <= address;
                SEL_EXT2: ext2_q      <= address;
                SEL_EXT3: ext3_q      <= address;
                default:  base_mode_q <= base_mode_q;
            endcase
        end
    end

    logic diff_en;
    logic read_strobe_en;
    logic mask_en;

    assign diff_en        = !ext1_q[EXT_DIFF_OFF_BIT];
    assign read_strobe_en = X8_PART && ext1_q[EXT_READ_STB_BIT];
    assign mask_en        = !read_strobe_en;

    // Per-bank open flag and row
    logic [NUM_BANKS-1:0] open_q;
    logic [ADDR_W-1:0]    row_q [NUM_BANKS];
    logic                 access_cmd;
    logic                 bank_hit_open;

    assign bank_hit_open = open_q[bank];
    assign access_cmd    = (cmd == CMD_READ || cmd == CMD_WRITE) && bank_hit_open;

    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
        logic hit;
        assign hit = (bank == BANK_W'(b));
        always_ff @(posedge diff_clock)
        begin
            if (link_rst_q)
            begin
                open_q[b] <= 1'b0;
                row_q[b]  <= '0;
            end
            else if (cmd == CMD_ACTIVATE && hit)
            begin
                open_q[b] <= 1'b1;
                row_q[b]  <= address;
            end
            else if (cmd == CMD_PRECHARGE && (precharge_all_flag || hit))
                open_q[b] <= 1'b0;
            else if (access_cmd && hit && precharge_all_flag)
            begin
                // Auto close at the command; the burst keeps its row
                open_q[b] <= 1'b0;
            end
        end
    end

    // Backing store: bank, low row bits, column
    logic [DQ_W-1:0]   mem [2**MEM_AW];
    logic [MEM_AW-1:0] cmd_idx;
    logic [ADDR_W-1:0] cur_row;

    assign cur_row = row_q[bank];
    assign cmd_idx = {bank, cur_row[ROW_IDX_W-1:0], address[COL_IDX_W-1:1], 1'b0};

    // First beat of each pair, caught at the fall
    logic [DQ_W-1:0]  fall_dq_q;
    logic [LANES-1:0] fall_mask_q;

    always_ff @(negedge diff_clock)
    begin
        fall_dq_q   <= dq_in;
        fall_mask_q <= {high_byte_mask, low_byte_mask};
    end

    function automatic logic [DQ_W-1:0] merge_beat(
        input logic [DQ_W-1:0]  old_w,
        input logic [DQ_W-1:0]  new_w,
        input logic [LANES-1:0] mask,
        input logic             use_mask
    );
        logic [DQ_W-1:0] res;
        res = new_w;
        for (int l = 0; l < LANES; l++)
        begin
            // An x8 part never writes its upper lane
            if ((use_mask && mask[l]) || (X8_PART && l == 1))
                res[l*BYTE_W +: BYTE_W] = old_w[l*BYTE_W +: BYTE_W];
        end
        return res;
    endfunction

    // Write burst: one beat pair stored per rising edge
    wr_state_t         wr_state_q;
    logic [MEM_AW-1:0] wr_idx_q;
    logic [1:0]        wr_left_q;
    logic [MEM_AW-1:0] wr_idx_hi;

    assign wr_idx_hi = wr_idx_q | MEM_AW'(1);

    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
        begin
            wr_state_q <= WR_IDLE;
            wr_idx_q   <= '0;
            wr_left_q  <= '0;
        end
        else if (cmd == CMD_WRITE && bank_hit_open)
        begin
            wr_state_q <= WR_BURST;
            wr_idx_q   <= cmd_idx;
            wr_left_q  <= PAIRS_LAST;
        end
        else
        begin
            case (wr_state_q)
                WR_BURST:
                begin
                    wr_idx_q  <= wr_idx_q + IDX_STEP;
                    wr_left_q <= wr_left_q - 1'b1;
                    if (wr_left_q == '0)
                    begin
                        wr_state_q <= WR_IDLE;
                    end
                end
                default: wr_state_q <= WR_IDLE;
            endcase
        end
    end

    always_ff @(posedge diff_clock)
    begin
        if (wr_state_q == WR_BURST)
        begin
            mem[wr_idx_q]  <= merge_beat(mem[wr_idx_q], fall_dq_q, fall_mask_q, mask_en);
            mem[wr_idx_hi] <= merge_beat(mem[wr_idx_hi], dq_in,
                                         {high_byte_mask, low_byte_mask}, mask_en);
        end
    end

    // Read fetch into the FIFO, stalled by its ready
    stream_if #(.W(PAIR_W)) fetch_s ();
    stream_if #(.W(PAIR_W)) drain_s ();

    stream_fifo #(.W(PAIR_W), .DEPTH(FIFO_DEPTH)) u_read_fifo (
        .clk   (diff_clock),
        .rst   (link_rst_q),
        .in_s  (fetch_s),
        .out_s (drain_s)
    );

    logic [MEM_AW-1:0] rd_idx_q;
    logic [1:0]        rd_left_q;
    logic [1:0]        lat_q;
    logic [PAIR_W-1:0] out_pair_q;
    logic              out_valid_q;

    assign fetch_s.valid = (rd_left_q != '0);
    assign fetch_s.data  = {mem[rd_idx_q | MEM_AW'(1)], mem[rd_idx_q]};
    assign drain_s.ready = (lat_q == '0);

    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
        begin
            rd_idx_q  <= '0;
            rd_left_q <= '0;
        end
        else if (cmd == CMD_READ && bank_hit_open)
        begin
            rd_idx_q  <= cmd_idx;
            rd_left_q <= PAIRS_ALL;
        end
        else if (fetch_s.valid && fetch_s.ready)
        begin
            rd_idx_q  <= rd_idx_q + IDX_STEP;
            rd_left_q <= rd_left_q - 1'b1;
        end
    end

    // A fresh read holds the drain for the latency
    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
            lat_q <= '0;
        else if (cmd == CMD_READ && bank_hit_open)
            lat_q <= LAT_LOAD;
        else if (lat_q != '0)
            lat_q <= lat_q - 1'b1;
    end

    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
        begin
            out_valid_q <= 1'b0;
            out_pair_q  <= '0;
        end
        else
        begin
            out_valid_q <= drain_s.valid && drain_s.ready;
            if (drain_s.valid && drain_s.ready)
                out_pair_q <= drain_s.data;
        end
    end

    // First beat in the high phase, second in the low phase
    assign dq_out = diff_clock ? out_pair_q[DQ_W-1:0] : out_pair_q[PAIR_W-1:DQ_W];
    assign dq_oe  = out_valid_q;

    assign low_byte_strobe_out    = diff_clock;
    assign low_byte_strobe_oe     = out_valid_q;
    assign low_byte_strobe_n_out  = !diff_clock;
    assign low_byte_strobe_n_oe   = out_valid_q && diff_en;
    assign high_byte_strobe_out   = diff_clock;
    assign high_byte_strobe_oe    = out_valid_q && !X8_PART;
    assign high_byte_strobe_n_out = !diff_clock;
    assign high_byte_strobe_n_oe  = out_valid_q && !X8_PART && diff_en;
    assign read_only_strobe_out   = diff_clock;
    assign read_only_strobe_oe    = out_valid_q && read_strobe_en;
    assign read_only_strobe_n_out = !diff_clock;
    assign read_only_strobe_n_oe  = out_valid_q && read_strobe_en && diff_en;

    // Status crosses to clk by a four-phase handshake
    logic [STATUS_W-1:0] live;
    logic [STATUS_W-1:0] snap_q;
    logic                req_q;
    logic                ack_s1_q;
    logic                ack_s2_q;
    logic                req_s1_q;
    logic                req_s2_q;
    logic                ack_q;
    logic [STATUS_W-1:0] status_q;

    assign live = {ext3_q, ext2_q, ext1_q, base_mode_q, open_q};

    always_ff @(posedge diff_clock)
    begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
    end

    always_ff @(posedge diff_clock)
    begin
        if (link_rst_q)
        begin
            req_q  <= 1'b0;
            snap_q <= '0;
        end
        else if (!req_q && !ack_s2_q && live != snap_q)
        begin
            snap_q <= live;
            req_q  <= 1'b1;
        end
        else if (req_q && ack_s2_q)
            req_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q    <= 1'b0;
            status_q <= '0;
        end
        else if (req_s2_q && !ack_q)
        begin
            // Snapshot is stable while the request stands
            status_q <= snap_q;
            ack_q    <= 1'b1;
        end
        else if (!req_s2_q)
            ack_q <= 1'b0;
    end

    assign bank_open = status_q[NUM_BANKS-1:0];
    assign base_mode = status_q[NUM_BANKS +: ADDR_W];
    assign ext_mode1 = status_q[NUM_BANKS + ADDR_W +: ADDR_W];
    assign ext_mode2 = status_q[NUM_BANKS + 2*ADDR_W +: ADDR_W];
    assign ext_mode3 = status_q[NUM_BANKS + 3*ADDR_W +: ADDR_W];

endmodule // ddr_pin_device
`default_nettype wire

// ==== logic/ddr_pin_pkg.sv ====
// Shared constants and types for the DRAM command and data pin block
package ddr_pin_pkg;

    localparam int ADDR_W     = 14;
    localparam int BANK_W     = 2;
    localparam int NUM_BANKS  = 4;
    localparam int DQ_W       = 16;
    localparam int LANES      = 2;
    localparam int BYTE_W     = 8;
    localparam int PAIR_W     = 2 * DQ_W;
    localparam int STATUS_W   = 4 * ADDR_W + NUM_BANKS;

    // Address bit positions with a special meaning
    localparam int PRECHARGE_ALL_BIT = 10;
    localparam int EXT_DIFF_OFF_BIT  = 10;
    localparam int EXT_READ_STB_BIT  = 11;

    // Bank select values during a mode load cycle
    localparam logic [BANK_W-1:0] SEL_BASE = 2'h0;
    localparam logic [BANK_W-1:0] SEL_EXT1 = 2'h1;
    localparam logic [BANK_W-1:0] SEL_EXT2 = 2'h2;
    localparam logic [BANK_W-1:0] SEL_EXT3 = 2'h3;

    localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;

    // Burst length in beats, latency in link clock cycles
    localparam int BURST_LEN  = 4;
    localparam int BURST_PAIRS = BURST_LEN / 2;
    localparam int READ_LAT   = 3;
    localparam int FIFO_DEPTH = 32;

    // Command code is {chip select, row strobe, column strobe, write enable}
    typedef enum logic [3:0] {
        CMD_MODE_LOAD  = 4'h0,
        CMD_REFRESH    = 4'h1,
        CMD_PRECHARGE  = 4'h2,
        CMD_ACTIVATE   = 4'h3,
        CMD_WRITE      = 4'h4,
        CMD_READ       = 4'h5,
        CMD_BURST_STOP = 4'h6,
        CMD_NOP        = 4'h7,
        CMD_DESELECT   = 4'h8
    } cmd_t;

    typedef enum logic [0:0] {
        WR_IDLE  = 1'b0,
        WR_BURST = 1'b1
    } wr_state_t;

endpackage

// ==== logic/stream_if.sv ====
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/stream_fifo.sv ====
// Single-clock FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 32
) (
    input  wire logic  clk,
    input  wire logic  rst,
    stream_if.sink     in_s,
    stream_if.source   out_s
);
    // Depth must be a power of two: pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_q != FULL);
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem[rp_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_q] <= in_s.data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            case ({push, pop})
                2'b10:   cnt_q <= cnt_q + 1'b1;
                2'b01:   cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // stream_fifo
`default_nettype wire

// ==== dv/ddr_pin_chk.sv ====
// Concurrent checks on the DRAM pin block
`timescale 1ns/1ps
`default_nettype none
module ddr_pin_chk #(
    parameter bit X8_PART = 1'b0
) (
    input wire logic                              clk,
    input wire logic                              rst,
    input wire logic                              diff_clock,
    input wire logic                              chip_select_n,
    input wire logic                              row_strobe_n,
    input wire logic                              col_strobe_n,
    input wire logic                              write_enable_n,
    input wire logic                              bank_select_bit0,
    input wire logic                              bank_select_bit1,
    input wire logic [ddr_pin_pkg::ADDR_W-1:0]    address,
    input wire logic                              dq_oe,
    input wire logic                              low_byte_strobe_oe,
    input wire logic                              low_byte_strobe_n_oe,
    input wire logic                              high_byte_strobe_oe,
    input wire logic                              read_only_strobe_oe,
    input wire logic [ddr_pin_pkg::ADDR_W-1:0]    base_mode,
    input wire logic [ddr_pin_pkg::ADDR_W-1:0]    ext_mode1,
    input wire logic [ddr_pin_pkg::NUM_BANKS-1:0] bank_open
);
    import ddr_pin_pkg::*;

    logic [2:0]        cmd_w;
    logic [BANK_W-1:0] bank_w;
    logic              go_w;
    logic [ADDR_W-1:0] base_op_q;
    logic [ADDR_W-1:0] ext1_op_q;
    logic [3:0]        rd_age_q;

    assign cmd_w  = {row_strobe_n, col_strobe_n, write_enable_n};
    assign bank_w = {bank_select_bit1, bank_select_bit0};
    assign go_w   = !chip_select_n;

    // Separate operands per register
    always_ff @(posedge diff_clock)
    begin
        if (go_w && cmd_w == 3'h0 && bank_w == SEL_BASE)
            base_op_q <= address;
        if (go_w && cmd_w == 3'h0 && bank_w == SEL_EXT1)
            ext1_op_q <= address;
    end

    // Saturates, so old reads never alias
    always_ff @(posedge diff_clock)
    begin
        if (rst)
            rd_age_q <= 4'hf;
        else if (go_w && cmd_w == 3'h5)
            rd_age_q <= 4'h0;
        else if (rd_age_q != 4'hf)
            rd_age_q <= rd_age_q + 4'h1;
    end

    default clocking cb @(posedge diff_clock);
    endclocking
    default disable iff (rst);

    lane_strobe_a: assert property (low_byte_strobe_oe == dq_oe)
        else $error("low strobe enable");
    upper_lane_a: assert property (high_byte_strobe_oe == (dq_oe && !X8_PART))
        else $error("high strobe enable");
    comp_strobe_a: assert property (
        low_byte_strobe_n_oe == (dq_oe && !ext_mode1[EXT_DIFF_OFF_BIT]))
        else $error("complement enable");
    read_strobe_a: assert property (
        read_only_strobe_oe |-> X8_PART && ext_mode1[EXT_READ_STB_BIT])
        else $error("read strobe unselected");
    burst_len_a: assert property ($rose(dq_oe) |-> dq_oe[*2] ##1 !dq_oe)
        else $error("burst length");
    read_lat_a: assert property ($rose(dq_oe) |-> rd_age_q == 4'h4)
        else $error("read latency");
    base_load_a: assert property (go_w && cmd_w == 3'h0 && bank_w == SEL_BASE
        |-> ##[1:8] base_mode == base_op_q)
        else $error("base mode load");
    ext_load_a: assert property (go_w && cmd_w == 3'h0 && bank_w == SEL_EXT1
        |-> ##[1:8] ext_mode1 == ext1_op_q)
        else $error("ext mode load");
    close_all_a: assert property (go_w && cmd_w == 3'h2 && address[PRECHARGE_ALL_BIT]
        |-> ##[1:8] bank_open == '0)
        else $error("precharge all");

    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
        open_bank_a: assert property (go_w && cmd_w == 3'h3 && bank_w == b
            |-> ##[1:8] bank_open[b])
            else $error("activate");
        close_bank_a: assert property (go_w && cmd_w == 3'h2 && bank_w == b
            |-> ##[1:8] !bank_open[b])
            else $error("precharge");
    end

    rd_burst_c: cover property ($rose(dq_oe));
    pre_all_c: cover property (go_w && cmd_w == 3'h2 && address[PRECHARGE_ALL_BIT]);
    comp_on_c: cover property (low_byte_strobe_n_oe);
endmodule // ddr_pin_chk

bind ddr_pin_device ddr_pin_chk #(.X8_PART(X8_PART)) ddr_pin_chk_i (.clk, .rst,
    .diff_clock, .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
    .bank_select_bit0, .bank_select_bit1, .address, .dq_oe, .low_byte_strobe_oe,
    .low_byte_strobe_n_oe, .high_byte_strobe_oe, .read_only_strobe_oe, .base_mode,
    .ext_mode1, .bank_open);
`default_nettype wire

// ==== dv/ddr_ctl_model.sv ====
// Controller model for the DRAM pin block
`timescale 1ns/1ps
`default_nettype none
module ddr_ctl_model (
    output logic                           diff_clock,
    output logic [3:0]                     cmd_n,
    output logic [ddr_pin_pkg::BANK_W-1:0] bank,
    output logic [ddr_pin_pkg::ADDR_W-1:0] addr,
    output logic [ddr_pin_pkg::DQ_W-1:0]   dq,
    output logic [ddr_pin_pkg::LANES-1:0]  mask
);
    import ddr_pin_pkg::*;

    // Free-running, phase unrelated to clk
    initial
    begin
        diff_clock = 1'b0;
        cmd_n = CMD_DESELECT;
        bank = '0;
        addr = '0;
        dq = '0;
        mask = '0;
        #13;
        forever
            #40 diff_clock = ~diff_clock;
    end

    task automatic issue(input logic [3:0] c, input int b, input logic [ADDR_W-1:0] a);
        @(posedge diff_clock);
        #1;
        cmd_n = c;
        bank = BANK_W'(b);
        addr = a;
        @(posedge diff_clock);
        #1;
        cmd_n = CMD_NOP;
        addr = ~a;
    endtask

    // Write latency is zero: beats follow at once
    task automatic wr(input int b, input logic [63:0] d, input logic [7:0] m);
        issue(CMD_WRITE, b, '0);
        for (int i = 0; i < 4; i++)
        begin
            dq = d[16*i +: 16];
            mask = m[2*i +: 2];
            if (i[0])
                @(posedge diff_clock);
            else
                @(negedge diff_clock);
            #1;
        end
        // Released lines show no stale beat
        dq = ~dq;
        mask = ~mask;
    endtask
endmodule // ddr_ctl_model
`default_nettype wire

// ==== dv/test_sdram_command_data_pins.sv ====
// Testbench for the DRAM pin block
`timescale 1ns/1ps
`default_nettype none
module test_sdram_command_data_pins;
    import ddr_pin_pkg::*;

    logic                 clk;
    logic                 rst;
    logic                 dck;
    logic [3:0]           cmd_n;
    logic [BANK_W-1:0]    bank;
    logic [ADDR_W-1:0]    addr;
    logic [DQ_W-1:0]      dq_w;
    logic [DQ_W-1:0]      dq_out;
    logic [LANES-1:0]     mask;
    logic                 dq_oe;
    logic [3:0]           stb_oe;
    logic [ADDR_W-1:0]    modes [4];
    logic [NUM_BANKS-1:0] bank_open;
    int                   err_total;
    int                   checked;
    int                   cycles;

    ddr_ctl_model ddr_ctl_model_i (.diff_clock(dck), .cmd_n(cmd_n), .bank(bank),
        .addr(addr), .dq(dq_w), .mask(mask));

    ddr_pin_device #(.X8_PART(1'b0)) ddr_pin_device_i (
        .clk(clk), .rst(rst), .diff_clock(dck), .chip_select_n(cmd_n[3]),
        .row_strobe_n(cmd_n[2]), .col_strobe_n(cmd_n[1]), .write_enable_n(cmd_n[0]),
        .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]), .address(addr),
        .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe),
        .low_byte_mask(mask[0]), .high_byte_mask(mask[1]), .low_byte_strobe_in(1'b0),
        .low_byte_strobe_out(), .low_byte_strobe_oe(stb_oe[3]),
        .low_byte_strobe_n_out(), .low_byte_strobe_n_oe(stb_oe[1]),
        .high_byte_strobe_in(1'b0), .high_byte_strobe_out(),
        .high_byte_strobe_oe(stb_oe[2]), .high_byte_strobe_n_out(),
        .high_byte_strobe_n_oe(), .read_only_strobe_out(),
        .read_only_strobe_oe(stb_oe[0]), .read_only_strobe_n_out(),
        .read_only_strobe_n_oe(), .base_mode(modes[0]), .ext_mode1(modes[1]),
        .ext_mode2(modes[2]), .ext_mode3(modes[3]), .bank_open(bank_open));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic settle();
        repeat (6) @(posedge dck);
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic rd(input int b, output logic [63:0] got, output logic [3:0] oes);
        int n;
        n = 0;
        ddr_ctl_model_i.issue(CMD_READ, b, '0);
        while (dq_oe !== 1'b1 && n < 12)
        begin
            @(posedge dck);
            #20;
            n++;
        end
        oes = stb_oe;
        for (int i = 0; i < 4; i++)
        begin
            got[16*i +: 16] = dq_out;
            #40;
        end
        chk(dq_oe, 1'b0, "oe after burst");
    endtask

    task automatic t_modes();
        logic [ADDR_W-1:0] ops [4];
        ops = '{14'h0a53, 14'h0400, 14'h2a5c, 14'h3c3c};
        for (int s = 0; s < 4; s++)
            ddr_ctl_model_i.issue(CMD_MODE_LOAD, s, ops[s]);
        settle();
        for (int s = 0; s < 4; s++)
            chk(modes[s], ops[s], "mode register");
    endtask

    task automatic t_banks();
        logic [3:0] idle [3];
        idle = '{CMD_REFRESH, CMD_BURST_STOP, CMD_NOP};
        for (int b = 0; b < 4; b++)
            ddr_ctl_model_i.issue(CMD_ACTIVATE, b, ADDR_W'(b));
        settle();
        chk(bank_open, 4'hf, "activate");
        ddr_ctl_model_i.issue(CMD_PRECHARGE, 2, 14'h0000);
        settle();
        chk(bank_open, 4'hb, "precharge one");
        ddr_ctl_model_i.issue(4'hb, 2, 14'h0000);
        for (int i = 0; i < 3; i++)
            ddr_ctl_model_i.issue(idle[i], 2, 14'h0400);
        settle();
        chk(bank_open, 4'hb, "ignored commands");
        ddr_ctl_model_i.issue(CMD_PRECHARGE, 1, 14'h0400);
        settle();
        chk(bank_open, 4'h0, "precharge all");
    endtask

    task automatic t_closed();
        logic [63:0] got;
        logic [3:0]  oes;
        rd(1, got, oes);
        chk(oes, 4'h0, "closed bank read");
    endtask

    task automatic t_rw();
        logic [63:0] got;
        logic [3:0]  oes;
        ddr_ctl_model_i.issue(CMD_ACTIVATE, 3, 14'h0001);
        ddr_ctl_model_i.wr(3, 64'h4444_3333_2222_1111, 8'h00);
        ddr_ctl_model_i.wr(3, 64'hdddd_cccc_bbbb_aaaa, 8'h39);
        rd(3, got, oes);
        chk(got, 64'hdddd_3333_22bb_aa11, "masked write");
        chk(oes, 4'hc, "single strobes");
        ddr_ctl_model_i.issue(CMD_MODE_LOAD, 1, 14'h0000);
        settle();
        rd(3, got, oes);
        chk(got, 64'hdddd_3333_22bb_aa11, "readback 2");
        chk(oes, 4'he, "diff strobes");
    endtask

    initial
    begin
        clk = 1'b0;
        forever
            #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        rst = 1'b1;
        // Longer than two cycles to span five link edges
        repeat (5) @(posedge dck);
        @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (5) @(posedge dck);
        t_modes();
        t_banks();
        t_closed();
        t_rw();
        complete_run();
    end
endmodule // test_sdram_command_data_pins
`default_nettype wire
